// ==== src/pic_params.svh ====
// Constants for the parallel interface clocking block.
// Assumes inclusion from the package and the design file only.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_PAB_DEPTH 4
`define PIC_PAB_PTR_W 2
`define PIC_PAB_HALF 2'h2
`define PIC_DIV_W 4
`define PIC_DIV_FULL 4'h4
`define PIC_RATE_FULL 1'h0
`define PIC_RATE_HALF 1'h1
`define PIC_SEL_HOST 1'h0
`define PIC_SEL_REF 1'h1
`endif

// ==== src/pic_pkg.sv ====
// Types for the parallel interface clocking block.
// Assumes pic_params.svh is on the include path.
`include "pic_params.svh"
package pic_pkg;
    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] data;
    } pic_char_t;
    typedef struct packed {
        logic tx_clock_source_select;
        logic tx_output_rate_select;
        logic rx_clock_source_select;
        logic ref_half_rate;
        logic rx_half_rate;
    } pic_cfg_t;
    typedef enum logic [1:0] {
        PIC_IDLE,
        PIC_RUN,
        PIC_ERR
    } pic_state_t;
endpackage : pic_pkg

// ==== src/pic_top.sv ====
// Parallel interface clocking: phase-align buffer, transmit clock output
// and receive interface clock for one channel.
// Assumes one core_clk sampling all pins; host strobe and receive edge
// arrive as pins and are synchronised here.
//
// Behaviour
// RQ1: Select 0 captures transmit characters on host character clock.
// RQ2: Host clock matches transmit output frequency, any phase.
// RQ3: Buffer absorbs half a character of host phase drift.
// RQ4: Drift beyond buffer capacity raises error flag until reinitialised.
// RQ5: Writing 0 to recenter latch recenters buffer pointers.
// RQ6: After error drops, every later character is captured correctly.
// RQ7: Transmit clock output at reference rate, or twice when rate 1.
// RQ8: Transmit clock output derived from internal character clock.
// RQ9: Reference clock selectable for transmit and receive interfaces.
// RQ10: Half-rate reference samples inputs on both edges.
// RQ11: Half-rate reference presents outputs on both edges.
// RQ12: Receive clock select chooses receive interface clock.
// RQ13: Full rate: complementary clocks at character rate, data on rise.
// RQ14: Half rate: complementary clocks at half rate, data both edges.
// RQ15: Transmit inputs captured on selected clock rising edge.
// RQ16: Error flag also clears when word sync sequence is sent.
// RQ17: Small elastic store, pointers half full on recenter.
`timescale 1ns/1ns
`include "pic_params.svh"
module pic_top
    import pic_pkg::*;
#(
    parameter int DEPTH = `PIC_PAB_DEPTH,
    parameter int PTR_W = `PIC_PAB_PTR_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic host_tx_char_clock,
    input wire logic reference_clock_pin,
    input wire logic rx_recovered_clock,
    input wire pic_char_t tx_in,
    input wire pic_cfg_t cfg,
    input wire logic phase_buffer_recenter,
    input wire logic word_sync_sent,
    input wire logic [7:0] rx_char,
    output logic tx_path_error_flag,
    output pic_char_t tx_out,
    output logic tx_out_valid,
    output logic tx_clock_output,
    output logic [7:0] rx_parallel_data,
    output logic rx_interface_clock_out,
    output logic rx_interface_clock_out_n
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; stage 0 is read only by stage 1
    logic [1:0] hclk_s0_q, hclk_s1_q;
    logic [1:0] ref_s0_q, ref_s1_q;
    logic [1:0] rxc_s0_q, rxc_s1_q;
    logic hclk_old_q, ref_old_q, rxc_old_q;
    pic_char_t din_s0_q, din_s1_q;
    logic rec_s0_q, rec_s1_q, rec_old_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hclk_s0_q <= 2'h0;
            hclk_s1_q <= 2'h0;
            ref_s0_q <= 2'h0;
            ref_s1_q <= 2'h0;
            rxc_s0_q <= 2'h0;
            rxc_s1_q <= 2'h0;
            hclk_old_q <= 1'h0;
            ref_old_q <= 1'h0;
            rxc_old_q <= 1'h0;
            din_s0_q <= '0;
            din_s1_q <= '0;
            // Idle low, so leaving reset gives no false recenter
            rec_s0_q <= 1'h0;
            rec_s1_q <= 1'h0;
            rec_old_q <= 1'h0;
        end else if (clk_en) begin
            hclk_s0_q <= {1'h0, host_tx_char_clock};
            hclk_s1_q <= hclk_s0_q;
            ref_s0_q <= {1'h0, reference_clock_pin};
            ref_s1_q <= ref_s0_q;
            rxc_s0_q <= {1'h0, rx_recovered_clock};
            rxc_s1_q <= rxc_s0_q;
            hclk_old_q <= hclk_s1_q[0];
            ref_old_q <= ref_s1_q[0];
            rxc_old_q <= rxc_s1_q[0];
            din_s0_q <= tx_in;
            din_s1_q <= din_s0_q;
            rec_s0_q <= phase_buffer_recenter;
            rec_s1_q <= rec_s0_q;
            rec_old_q <= rec_s1_q;
        end
    end

    logic hclk_rise, ref_rise, ref_fall, rxc_rise, rxc_fall;
    logic recenter_pulse;
    assign hclk_rise = hclk_s1_q[0] & ~hclk_old_q;
    assign ref_rise = ref_s1_q[0] & ~ref_old_q;
    assign ref_fall = ~ref_s1_q[0] & ref_old_q;
    assign rxc_rise = rxc_s1_q[0] & ~rxc_old_q;
    assign rxc_fall = ~rxc_s1_q[0] & rxc_old_q;
    // RQ5 falling write of 0
    assign recenter_pulse = rec_old_q & ~rec_s1_q;

    // Write strobe: host clock or reference edges
    logic wr_stb, rd_stb;
    always_comb begin
        // RQ1 RQ15 host clock rising edge
        if (cfg.tx_clock_source_select == `PIC_SEL_HOST) begin
            wr_stb = hclk_rise;
        // RQ9 RQ10 reference clock, both edges at half rate
        end else if (cfg.ref_half_rate) begin
            wr_stb = ref_rise | ref_fall;
        end else begin
            wr_stb = ref_rise;
        end
    end
    // RQ8 internal character clock is reference based
    assign rd_stb = cfg.ref_half_rate ? (ref_rise | ref_fall) : ref_rise;

    // RQ17 elastic store with half-full recentering
    pic_char_t mem_q [DEPTH];
    pic_char_t mem_d [DEPTH];
    logic [PTR_W:0] wp_q, wp_d, rp_q, rp_d;
    logic err_q, err_d;
    pic_char_t tout_q, tout_d;
    logic tval_q, tval_d;
    logic [PTR_W:0] fill;
    // Fault seen this cycle; beats a word sync clear
    logic err_set;
    assign fill = wp_q - rp_q;
    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        err_d = err_q;
        tout_d = tout_q;
        tval_d = 1'h0;
        err_set = 1'h0;
        if (recenter_pulse) begin
            // RQ5 RQ17 recenter pointers
            wp_d = {1'h0, `PIC_PAB_HALF};
            rp_d = '0;
            err_d = 1'h0;
        end else begin
            if (wr_stb) begin
                // RQ3 write while room remains
                if (fill < (PTR_W + 1)'(DEPTH) || rd_stb) begin
                    mem_d[wp_q[PTR_W-1:0]] = din_s1_q;
                    wp_d = wp_q + 1'h1;
                end else begin
                    // RQ4 overflow
                    err_set = 1'h1;
                end
            end
            if (rd_stb) begin
                if (fill != '0) begin
                    tout_d = mem_q[rp_q[PTR_W-1:0]];
                    tval_d = 1'h1;
                    rp_d = rp_q + 1'h1;
                end else begin
                    // RQ4 underflow
                    err_set = 1'h1;
                end
            end
            // RQ16 word sync clears flag; set wins
            if (err_set) begin
                err_d = 1'h1;
            end else if (word_sync_sent) begin
                err_d = 1'h0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q <= {1'h0, `PIC_PAB_HALF};
            rp_q <= '0;
            err_q <= 1'h0;
            tout_q <= '0;
            tval_q <= 1'h0;
        end else if (clk_en) begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            err_q <= err_d;
            tout_q <= tout_d;
            tval_q <= tval_d;
        end
    end
    assign tx_path_error_flag = err_q;
    assign tx_out = tout_q;
    assign tx_out_valid = tval_q;

    // Clock outputs follow synchronised edges
    logic txo_q, txo_d;
    logic rxo_q, rxo_d;
    logic rxon_q, rxon_d;
    logic [7:0] rxd_q, rxd_d;
    logic rx_edge, rx_data_edge;
    always_comb begin
        // RQ7 RQ8 follow reference, toggle twice as fast at rate 1
        if (cfg.tx_output_rate_select == `PIC_RATE_HALF) begin
            txo_d = (ref_rise | ref_fall) ? 1'h1 :
                    (txo_q ? 1'h0 : txo_q);
        end else begin
            txo_d = ref_s1_q[0];
        end
        // RQ12 receive clock source
        if (cfg.rx_clock_source_select == `PIC_SEL_REF) begin
            rx_edge = ref_rise;
            rx_data_edge = cfg.rx_half_rate ? (ref_rise | ref_fall) : ref_rise;
        end else begin
            rx_edge = rxc_rise;
            rx_data_edge = cfg.rx_half_rate ? (rxc_rise | rxc_fall) : rxc_rise;
        end
        // RQ13 RQ14 true clock toggles per character or halves
        if (cfg.rx_half_rate) begin
            rxo_d = rx_data_edge ? ~rxo_q : rxo_q;
        end else begin
            rxo_d = rx_edge ? 1'h1 : (rx_data_edge ? rxo_q : 1'h0);
        end
        // RQ11 RQ13 RQ14 data follows selected edges
        rxd_d = rx_data_edge ? rx_char : rxd_q;
        // Complement kept in its own flop so both pins leave registers
        rxon_d = ~rxo_d;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txo_q <= 1'h0;
            rxo_q <= 1'h0;
            rxon_q <= 1'h1;
            rxd_q <= 8'h00;
        end else if (clk_en) begin
            txo_q <= txo_d;
            rxo_q <= rxo_d;
            rxon_q <= rxon_d;
            rxd_q <= rxd_d;
        end
    end
    assign tx_clock_output = txo_q;
    assign rx_interface_clock_out = rxo_q;
    assign rx_interface_clock_out_n = rxon_q;
    assign rx_parallel_data = rxd_q;

    // RQ4 error sticks until recenter or word sync
    a_err_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && err_q && !recenter_pulse && !word_sync_sent |=> err_q)
        else $error("error flag dropped without clear"); // RQ4
    // RQ5 recenter sets half full
    a_recenter_half: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && recenter_pulse |=> wp_q - rp_q == (PTR_W + 1)'(`PIC_PAB_HALF))
        else $error("recenter not half full"); // RQ5
    // RQ17 fill bounded
    a_fill_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        fill <= (PTR_W + 1)'(DEPTH))
        else $error("buffer fill beyond depth"); // RQ17
    // RQ6 clean read yields valid output
    a_read_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && rd_stb && fill != '0 && !recenter_pulse |=> tval_q)
        else $error("read lost character"); // RQ6
    // RQ1 capture on host edge
    a_host_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !cfg.tx_clock_source_select && wr_stb && !rd_stb &&
        !recenter_pulse && fill < (PTR_W + 1)'(DEPTH) |=> wp_q == $past(wp_q) + 1'h1)
        else $error("host edge not captured"); // RQ1
    // RQ13 full rate complement
    a_rx_compl: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_interface_clock_out_n == ~rx_interface_clock_out)
        else $error("receive clocks not complementary"); // RQ13
    // RQ14 data changes only on selected edge
    a_rx_data_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !rx_data_edge |=> $stable(rx_parallel_data))
        else $error("receive data moved off edge"); // RQ14
    // RQ7 full rate follows reference
    a_tx_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !cfg.tx_output_rate_select |=> txo_q == $past(ref_s1_q[0]))
        else $error("transmit clock not following reference"); // RQ7
    c_overflow: cover property (@(posedge core_clk) disable iff (!rst_n)
        !err_q ##1 err_q);
    c_recenter: cover property (@(posedge core_clk) disable iff (!rst_n)
        err_q ##1 recenter_pulse);
    c_tx_char: cover property (@(posedge core_clk) disable iff (!rst_n)
        tval_q);
    // RQ16 word sync clears flag when no new fault
    a_sync_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && word_sync_sent && !err_set && !recenter_pulse |=> !err_q)
        else $error("word sync did not clear error"); // RQ16
    c_sync_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
        err_q && word_sync_sent ##1 !err_q);
    c_both_edges: cover property (@(posedge core_clk) disable iff (!rst_n)
        cfg.ref_half_rate && wr_stb && rd_stb && ref_fall);
endmodule : pic_top

// ==== testbench/pic_host_model.sv ====
// Host side of the transmit path: character clock and character stream.
// Assumes the bench sets the half period in core_clk cycles.
`timescale 1ns/1ns
module pic_host_model
    import pic_pkg::*;
(
    input wire logic core_clk,
    input wire logic run,
    input wire logic [3:0] half,
    input wire logic [7:0] start,
    output logic host_clk,
    output pic_char_t tx_char
);
    logic [3:0] cnt;
    initial begin
        host_clk = 1'h0;
        cnt = 4'h0;
        tx_char = '0;
    end
    // same rate as ref when half is 4, any phase
    always @(posedge core_clk) begin
        if (!run) begin
            host_clk <= 1'h0;
            cnt <= 4'h0;
            tx_char <= pic_char_t'({2'h0, start});
        end else if (cnt == half - 4'h1) begin
            cnt <= 4'h0;
            host_clk <= ~host_clk;
            // Change on the fall so the rise sees settled data
            if (host_clk) begin
                tx_char <= pic_char_t'(tx_char + 10'h1);
            end
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : pic_host_model

// ==== testbench/tb_pic_top.sv ====
// Bench for the parallel interface clocking block.
// Assumes the host model drives the host clock and characters.
`timescale 1ns/1ns
module tb_pic_top;
    import pic_pkg::*;
    logic core_clk, rstn, run, rc, ws, ref_clk, rec_clk, tco_q, rxo_q;
    logic [3:0] half;
    logic [7:0] start, rx_char, rx_data, rxc_q, rxd_prev;
    logic [9:0] last;
    pic_cfg_t cfg;
    pic_char_t tx_in, tx_out;
    logic host_clk, err, valid, tco, rxo, rxo_n;
    int fails, num_checks, n_tco, n_rx, skip, vchk, cyc, n_val, vrx;
    pic_host_model i_pic_host_model (.core_clk(core_clk), .run(run),
        .half(half), .start(start), .host_clk(host_clk), .tx_char(tx_in));
    pic_top i_pic_top (.core_clk(core_clk), .rstn(rstn), .clk_en(1'h1),
        .host_tx_char_clock(host_clk), .reference_clock_pin(ref_clk),
        .rx_recovered_clock(rec_clk), .tx_in(tx_in), .cfg(cfg),
        .phase_buffer_recenter(rc), .word_sync_sent(ws), .rx_char(rx_char),
        .tx_path_error_flag(err), .tx_out(tx_out), .tx_out_valid(valid),
        .tx_clock_output(tco), .rx_parallel_data(rx_data),
        .rx_interface_clock_out(rxo), .rx_interface_clock_out_n(rxo_n));
    function automatic logic [9:0] nxt(input logic [9:0] c);
        return c + 10'h1;
    endfunction : nxt
    task automatic end_sim();
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [9:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_n(input string nm, input int e, g);
        num_checks++;
        if (g < e - 1 || g > e + 1) begin
            fails++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_n
    task automatic recenter();
        @(posedge core_clk) rc <= 1'h1;
        repeat (2) @(posedge core_clk);
        rc <= 1'h0;
        skip = 4;
        repeat (12) @(posedge core_clk);
    endtask : recenter
    task automatic drift();
        vchk = 0;
        half <= 4'h3;
        for (int i = 0; i < 400 && err !== 1'h1; i++) @(posedge core_clk);
        chk("err_set", 10'h1, {9'h0, err});
        half <= 4'h4;
        repeat (100) @(posedge core_clk);
        chk("err_held", 10'h1, {9'h0, err});
    endtask : drift
    task automatic win(input string nm, input int et, er, ev);
        repeat (8) @(posedge core_clk);
        n_tco = 0;
        n_rx = 0;
        n_val = 0;
        vrx = 1;
        repeat (160) @(posedge core_clk);
        vrx = 0;
        chk_n({nm, "_tco"}, et, n_tco);
        chk_n({nm, "_rx"}, er, n_rx);
        chk_n({nm, "_val"}, ev, n_val);
    endtask : win
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    // Reference matches the host clock period of eight cycles
    initial begin
        ref_clk = 1'h0;
        forever begin
            repeat (4) @(posedge core_clk);
            ref_clk <= ~ref_clk;
        end
    end
    // Receive clock slower, so the source select shows in the counts
    initial begin
        rec_clk = 1'h0;
        forever begin
            repeat (5) @(posedge core_clk);
            rec_clk <= ~rec_clk;
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        rx_char <= 8'($urandom);
        rxc_q <= rx_char;
        rxd_prev <= rx_data;
        if (tco && !tco_q) n_tco++;
        if (rxo && !rxo_q) n_rx++;
        if (valid === 1'h1) n_val++;
        tco_q <= tco;
        rxo_q <= rxo;
        if (rstn && rxo_n !== ~rxo) begin
            chk("rx_clk_n", {9'h0, ~rxo}, {9'h0, rxo_n});
        end
        // New receive data must be the character offered one edge before
        if (rx_data !== rxd_prev) begin
            chk("rx_data", {2'h0, rxc_q}, {2'h0, rx_data});
            if (vrx != 0) chk("rx_align", {9'h0, ~rxo_q}, {9'h0, rxo});
        end
        if (valid === 1'h1 && vchk != 0) begin
            if (skip > 0) skip--;
            else chk("tx_out", nxt(last), tx_out);
            last = tx_out;
        end
        if (cyc > 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {rstn, run, rc, ws, tco_q, rxo_q} = '0;
        {fails, num_checks, vchk, skip, cyc, n_val, vrx} = '0;
        half = 4'h4;
        cfg = '0;
        last = '0;
        rx_char = 8'h0;
        rxc_q = 8'h0;
        rxd_prev = 8'h0;
        void'($urandom(45730));
        start = 8'($urandom);
        repeat (4) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (4 + $urandom % 8) @(posedge core_clk);
        run <= 1'h1;
        recenter();
        vchk = 1;
        win("base", 20, 16, 20);
        chk("err_idle", 10'h0, {9'h0, err});
        drift();
        recenter();
        chk("err_clr", 10'h0, {9'h0, err});
        vchk = 1;
        repeat (200) @(posedge core_clk);
        drift();
        @(posedge core_clk) ws <= 1'h1;
        @(posedge core_clk) ws <= 1'h0;
        repeat (4) @(posedge core_clk);
        chk("err_sync", 10'h0, {9'h0, err});
        cfg.tx_output_rate_select <= 1'h1;
        cfg.rx_half_rate <= 1'h1;
        win("fast", 40, 16, 20);
        cfg.rx_clock_source_select <= 1'h1;
        cfg.rx_half_rate <= 1'h0;
        win("ref", 40, 20, 20);
        // Reference clocks both sides at half rate: both edges used
        cfg.tx_clock_source_select <= 1'h1;
        cfg.ref_half_rate <= 1'h1;
        cfg.rx_half_rate <= 1'h1;
        win("both", 40, 20, 40);
        chk("err_both", 10'h0, {9'h0, err});
        end_sim();
    end
endmodule : tb_pic_top
